//--- core/cwr_ctrl.sv
// waveform generator control: enable, shutdown, restart, dead-band load
// assumes synchronous inputs; shutdown inputs are active low levels
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module cwr_ctrl
   import cwr_pkg::*;
(
   input  wire logic       clk_sys_i,    // system clock
   input  wire logic       srst_i,       // sync reset, high
   input  wire logic [2:0] addr_i,       // register index
   input  wire logic [7:0] wdata_i,      // write data
   input  wire logic       wr_i,         // write strobe
   input  wire logic       rd_i,         // read strobe
   output logic      [7:0] rdata_o,      // read data, next cycle
   input  wire logic [3:0] data_src_i,   // candidate data inputs
   input  wire logic [3:0] shdn_n_i,     // shutdown inputs, low active
   input  wire logic       sleep_i,      // sleep indication
   output logic      [3:0] out_o,        // waveform outputs a..d
   output logic      [5:0] dbr_act_o,    // active rising dead band
   output logic      [5:0] dbf_act_o,    // active falling dead band
   output logic            mode_bad_o,   // reserved mode selected
   output logic            clk_sel_o     // module clock select
);
   // ****************************************
   // registers
   // ****************************************
   logic       en_r;
   logic       ld_r;
   logic [2:0] mode_r;
   logic [3:0] pol_r;
   logic [5:0] dbr_r, dbf_r;
   logic [5:0] dbr_buf_r, dbf_buf_r;
   logic       shdn_r, ren_r;
   logic [1:0] lsbd_r, lsac_r;
   logic [3:0] src_en_r;
   logic [3:0] dsel_r;
   logic       cs_r;
   logic       din_r;
   logic       ld_fall_r;
   cwr_state_e st_r;
   logic [7:0] rdata_nxt;

   wire logic din      = data_src_i[dsel_r[1:0]];
   wire logic rise     = din & ~din_r;
   wire logic fall     = ~din & din_r;
   // level sensitive sources gated by their enables
   wire logic src_act  = |(~shdn_n_i & src_en_r);
   wire logic wr_con0  = wr_i && addr_i == CWR_OFS_CON0;
   wire logic wr_as0   = wr_i && addr_i == CWR_OFS_AS0;
   // override map {d,c,b,a}: second pair on b/d, first pair on a/c
   wire logic [3:0] ovr = {lsbd_r[1], lsac_r[1], lsbd_r[0], lsac_r[0]};

   function automatic logic mode_valid(input logic [2:0] m);
      mode_valid = (m <= CWR_MODE_PUSH);
   endfunction

   // ****************************************
   // configuration writes
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         en_r     <= 1'b0;
         mode_r   <= CWR_RST_BYTE[2:0];
         pol_r    <= CWR_RST_BYTE[3:0];
         dbr_r    <= CWR_RST_BYTE[5:0];
         dbf_r    <= CWR_RST_BYTE[5:0];
         ren_r    <= 1'b0;
         lsbd_r   <= 2'h0;
         lsac_r   <= 2'h0;
         src_en_r <= 4'h0;
         dsel_r   <= 4'h0;
         cs_r     <= 1'b0;
      end else if (wr_i) begin
         if (addr_i == CWR_OFS_CON0) begin
            en_r   <= wdata_i[CWR_BIT_EN];
            mode_r <= wdata_i[2:0];
         end else if (addr_i == CWR_OFS_CON1) begin
            pol_r <= wdata_i[3:0];
         end else if (addr_i == CWR_OFS_DBR) begin
            dbr_r <= wdata_i[5:0];
         end else if (addr_i == CWR_OFS_DBF) begin
            dbf_r <= wdata_i[5:0];
         end else if (addr_i == CWR_OFS_AS0) begin
            ren_r  <= wdata_i[CWR_BIT_REN];
            lsbd_r <= wdata_i[3:2];
            lsac_r <= wdata_i[1:0];
         end else if (addr_i == CWR_OFS_AS1) begin
            src_en_r <= wdata_i[3:0];
         end else if (addr_i == CWR_OFS_DAT) begin
            dsel_r <= wdata_i[3:0];
         end else if (addr_i == CWR_OFS_CLK) begin
            cs_r <= wdata_i[0];
         end
      end
   end

   // ****************************************
   // dead-band buffers and load bit
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ld_r      <= 1'b0;
         ld_fall_r <= 1'b0;
         dbr_buf_r <= 6'h00;
         dbf_buf_r <= 6'h00;
      end else if (!en_r) begin
         ld_r      <= 1'b0;
         ld_fall_r <= 1'b0;
         dbr_buf_r <= dbr_r;
         dbf_buf_r <= dbf_r;
      end else if (ld_r && ld_fall_r && rise) begin
         dbr_buf_r <= dbr_r;
         dbf_buf_r <= dbf_r;
         ld_r      <= 1'b0;
         ld_fall_r <= 1'b0;
      end else begin
         if (ld_r && fall) begin
            ld_fall_r <= 1'b1;
         end
         // en_r already high, so a same-write enable cannot set it
         if (wr_con0 && wdata_i[CWR_BIT_LD] && !ld_r) begin
            ld_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // shutdown flag and restart
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         shdn_r <= 1'b1;
      end else if (!en_r) begin
         shdn_r <= 1'b1;
      end else if (src_act) begin
         shdn_r <= 1'b1;
      end else if (wr_as0 && wdata_i[CWR_BIT_SHDN]) begin
         shdn_r <= 1'b1;
      end else if (ren_r) begin
         shdn_r <= 1'b0;
      end else if (wr_as0) begin
         shdn_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_r  <= CWR_ST_SHUT;
         din_r <= 1'b0;
      end else begin
         din_r <= din;
         case (st_r)
            CWR_ST_SHUT: if (!shdn_r && en_r) st_r <= CWR_ST_WAIT;
            CWR_ST_WAIT: if (shdn_r || !en_r) begin
               st_r <= CWR_ST_SHUT;
            end else if (rise) begin
               st_r <= CWR_ST_RUN;
            end
            CWR_ST_RUN: if (shdn_r || !en_r) st_r <= CWR_ST_SHUT;
            default: st_r <= CWR_ST_SHUT;
         endcase
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic [3:0] drv;
   always_comb begin
      drv = 4'h0;
      case (mode_r)
         CWR_MODE_HALF, CWR_MODE_PUSH: drv = {~din, din, ~din, din};
         CWR_MODE_FWD:  drv = {din, 1'b0, 1'b0, 1'b1};
         CWR_MODE_REV:  drv = {1'b0, 1'b1, din, 1'b0};
         default:       drv = {4{din}};
      endcase
   end
   wire logic [3:0] run_val = drv ^ pol_r;

   // sleep_i deliberately unused: logic runs on whatever clock remains
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         out_o <= 4'h0;
      end else if (!en_r) begin
         out_o <= 4'h0;
      end else if (st_r != CWR_ST_RUN || src_act || shdn_r) begin
         // override levels ignore polarity
         out_o <= ovr;
      end else if (!mode_valid(mode_r)) begin
         out_o <= 4'h0;
      end else begin
         out_o <= run_val;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         dbr_act_o  <= 6'h00;
         dbf_act_o  <= 6'h00;
         mode_bad_o <= 1'b0;
         clk_sel_o  <= 1'b0;
      end else begin
         dbr_act_o  <= dbr_buf_r;
         dbf_act_o  <= dbf_buf_r;
         mode_bad_o <= ~mode_valid(mode_r);
         clk_sel_o  <= cs_r;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_comb begin
      rdata_nxt = 8'h00;
      if (addr_i == CWR_OFS_CON0) begin
         rdata_nxt = {en_r, ld_r, 3'h0, mode_r};
      end else if (addr_i == CWR_OFS_CON1) begin
         rdata_nxt = {2'h0, din, 1'b0, pol_r};
      end else if (addr_i == CWR_OFS_DBR) begin
         rdata_nxt = {2'h0, dbr_r};
      end else if (addr_i == CWR_OFS_DBF) begin
         rdata_nxt = {2'h0, dbf_r};
      end else if (addr_i == CWR_OFS_AS0) begin
         rdata_nxt = {shdn_r, ren_r, 2'h0, lsbd_r, lsac_r};
      end else if (addr_i == CWR_OFS_AS1) begin
         rdata_nxt = {4'h0, src_en_r};
      end else if (addr_i == CWR_OFS_DAT) begin
         rdata_nxt = {4'h0, dsel_r};
      end else begin
         rdata_nxt = {7'h00, cs_r};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? rdata_nxt : 8'h00;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_no_clear_active: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      src_act && en_r |=> shdn_r)
      else $error("flag cleared with source");
   a_auto_restart: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && ren_r && !src_act && !(wr_as0 && wdata_i[CWR_BIT_SHDN])
      |=> !shdn_r || !en_r)
      else $error("auto restart missed");
   a_manual_hold: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && !ren_r && shdn_r && !wr_as0 |=> shdn_r)
      else $error("flag lost");
   a_resume_rise: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      st_r == CWR_ST_WAIT && !rise |=> st_r != CWR_ST_RUN)
      else $error("early run");
   a_start_shut: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      $rose(en_r) |-> shdn_r)
      else $error("enable not shut");
   a_ld_same_en: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      !en_r |=> !ld_r)
      else $error("load set with enable");
   a_ld_clear: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && ld_r && ld_fall_r && rise
      |=> !ld_r && dbr_buf_r == $past(dbr_r))
      else $error("load not done");
   a_ld_wait: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && ld_r && !rise |=> ld_r)
      else $error("load done without rise");
   a_bad_mode: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      mode_r[2] && mode_r[1] |=> mode_bad_o)
      else $error("reserved mode ok");
   a_good_mode: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      !(mode_r[2] && mode_r[1]) |=> !mode_bad_o)
      else $error("valid mode flagged");
   a_src_override: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && src_act |=> out_o == $past(ovr))
      else $error("override not driven");
   a_run_drive: assert property (
      @(posedge clk_sys_i) disable iff (srst_i)
      en_r && st_r == CWR_ST_RUN && !src_act && !shdn_r
      && mode_valid(mode_r)
      |=> out_o == $past(run_val))
      else $error("running output wrong");
endmodule // cwr_ctrl

//--- core/cwr_pkg.sv
// constants for the waveform generator shutdown and restart control
// assumes a single 25 MHz system clock and a plain register port
package cwr_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [2:0] CWR_OFS_CON0 = 3'h0;
   localparam logic [2:0] CWR_OFS_CON1 = 3'h1;
   localparam logic [2:0] CWR_OFS_DBR  = 3'h2;
   localparam logic [2:0] CWR_OFS_DBF  = 3'h3;
   localparam logic [2:0] CWR_OFS_AS0  = 3'h4;
   localparam logic [2:0] CWR_OFS_AS1  = 3'h5;
   localparam logic [2:0] CWR_OFS_DAT  = 3'h6;
   localparam logic [2:0] CWR_OFS_CLK  = 3'h7;
   // ****************************************
   // field positions
   // ****************************************
   localparam int CWR_BIT_EN   = 7;
   localparam int CWR_BIT_LD   = 6;
   localparam int CWR_BIT_SHDN = 7;
   localparam int CWR_BIT_REN  = 6;
   localparam int CWR_BIT_IN   = 5;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] CWR_RST_BYTE = 8'h00;
   // ****************************************
   // modes
   // ****************************************
   typedef enum logic [2:0] {
      CWR_MODE_ASTEER = 3'h0,
      CWR_MODE_SSTEER = 3'h1,
      CWR_MODE_FWD    = 3'h2,
      CWR_MODE_REV    = 3'h3,
      CWR_MODE_HALF   = 3'h4,
      CWR_MODE_PUSH   = 3'h5
   } cwr_mode_e;
   typedef enum logic [2:0] {
      CWR_ST_SHUT = 3'b001,
      CWR_ST_WAIT = 3'b010,
      CWR_ST_RUN  = 3'b100
   } cwr_state_e;
endpackage

//--- verif/cwr_ctrl_tb.sv
// bench for the waveform control block: registers, shutdown, restart
// assumes the stage model drives the shutdown lines
`timescale 1ns/10ps
module cwr_ctrl_tb;
   import cwr_pkg::*;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic sleep_i = 1'b0, mode_bad_o, clk_sel_o, rd_d = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, d1, d2;
   logic [3:0] data_src_i = 4'h0, shdn_n_i, out_o, fault = 4'h0, lv, ov;
   logic [5:0] dbr_act_o, dbf_act_o;
   logic [1:0] sel;
   logic [7:0] rq[$];
   int n_mismatch = 0, comparisons = 0;
   cwr_ctrl i_dut (
      .clk_sys_i  (clk_sys_i),
      .srst_i     (srst_i),
      .addr_i     (addr_i),
      .wdata_i    (wdata_i),
      .wr_i       (wr_i),
      .rd_i       (rd_i),
      .rdata_o    (rdata_o),
      .data_src_i (data_src_i),
      .shdn_n_i   (shdn_n_i),
      .sleep_i    (sleep_i),
      .out_o      (out_o),
      .dbr_act_o  (dbr_act_o),
      .dbf_act_o  (dbf_act_o),
      .mode_bad_o (mode_bad_o),
      .clk_sel_o  (clk_sel_o)
   );
   cwr_stage_model i_stage (.clk_sys_i(clk_sys_i), .fault_i(fault),
      .shdn_n_o(shdn_n_i));
   initial forever #20 clk_sys_i = ~clk_sys_i;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****************************************
   // register port and input drivers
   // ****************************************
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      rd_i <= 1'b1; addr_i <= a; rq.push_back(exp);
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
   endtask
   // only the selected input carries the level; the others the inverse
   task automatic set_data(input logic v);
      @(posedge clk_sys_i);
      data_src_i <= v ? (4'h1 << sel) : ~(4'h1 << sel);
      repeat (2) @(posedge clk_sys_i);
   endtask
   task automatic wait_out(input logic [3:0] exp);
      int i;
      // look at the settled output, away from the launching edge
      @(negedge clk_sys_i);
      for (i = 0; i < 50 && out_o !== exp; i++) @(negedge clk_sys_i);
      chk({4'h0, out_o}, {4'h0, exp});
      @(posedge clk_sys_i);
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk_sys_i) rd_d <= rd_i;
   always @(negedge clk_sys_i) begin
      if (rd_d) chk(rdata_o, rq.pop_front());
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h8154A059));
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      for (int a = 0; a < 8; a++) rd(3'(a), a == 4 ? 8'h80 : 8'h00);
      $display("test reset values done");
      for (int m = 0; m < 8; m++) begin
         wr(CWR_OFS_CON0, 8'(m));
         @(posedge clk_sys_i);
         #1 chk({7'h0, mode_bad_o}, {7'h0, m >= 6});
         rd(CWR_OFS_CON0, 8'(m));
      end
      $display("test modes done");
      // set-up order, enable last; mode 6 keeps running outputs at 0
      lv = 4'($urandom) | 4'h1;
      ov = {lv[3], lv[1], lv[2], lv[0]};
      sel = 2'($urandom);
      d1 = 8'($urandom) & 8'h3F;
      d2 = ~d1 & 8'h3F;
      wr(CWR_OFS_CON1, 8'h5);
      wr(CWR_OFS_DAT, {6'h0, sel});
      wr(CWR_OFS_AS0, {4'h8, lv});
      wr(CWR_OFS_AS1, 8'h01);
      wr(CWR_OFS_DBR, d1);
      wr(CWR_OFS_DBF, d2);
      wr(CWR_OFS_CLK, 8'h01);
      // buffer and clock select outputs trail their writes by flops
      repeat (2) @(negedge clk_sys_i);
      chk({2'h0, dbr_act_o}, d1);
      chk({2'h0, dbf_act_o}, d2);
      chk({7'h0, clk_sel_o}, 8'h01);
      rd(CWR_OFS_CON1, 8'h05);
      wr(CWR_OFS_CON0, 8'hC6);
      rd(CWR_OFS_CON0, 8'h86);
      wait_out(ov);
      $display("test enable done");
      fault <= 4'h1;
      wr(CWR_OFS_AS0, {4'h0, lv});
      rd(CWR_OFS_AS0, {4'h8, lv});
      fault <= 4'h0;
      rd(CWR_OFS_AS0, {4'h8, lv});
      wr(CWR_OFS_AS0, {4'h0, lv});
      rd(CWR_OFS_AS0, {4'h0, lv});
      chk({4'h0, out_o}, {4'h0, ov});
      set_data(1'b1);
      wait_out(4'h0);
      $display("test software restart done");
      fault <= 4'h1;
      wait_out(ov);
      wr(CWR_OFS_AS0, {4'h4, lv});
      rd(CWR_OFS_AS0, {4'hC, lv});
      fault <= 4'h0;
      repeat (3) @(posedge clk_sys_i);
      rd(CWR_OFS_AS0, {4'h4, lv});
      chk({4'h0, out_o}, {4'h0, ov});
      set_data(1'b0);
      set_data(1'b1);
      wait_out(4'h0);
      $display("test auto restart done");
      // buffer load while asleep on the fast oscillator
      sleep_i <= 1'b1;
      wr(CWR_OFS_DBR, d2);
      wr(CWR_OFS_CON0, 8'hC6);
      rd(CWR_OFS_CON0, 8'hC6);
      set_data(1'b0);
      chk({2'h0, dbr_act_o}, d1);
      set_data(1'b1);
      @(negedge clk_sys_i);
      chk({2'h0, dbr_act_o}, d2);
      rd(CWR_OFS_CON0, 8'h86);
      $display("test buffer load done");
      // steering mode drives every output; a and c inverted by polarity
      wr(CWR_OFS_CON0, 8'h01);
      wr(CWR_OFS_CON0, 8'h81);
      wait_out(ov);
      set_data(1'b0);
      set_data(1'b1);
      wait_out(4'hA);
      set_data(1'b0);
      wait_out(4'h5);
      $display("test running outputs done");
      repeat (3) @(posedge clk_sys_i);
      end_of_test();
   end
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule // cwr_ctrl_tb

//--- verif/cwr_stage_model.sv
// power switch stage model: reports faults on active low lines
// assumes the bench commands each fault level per source
`timescale 1ns/10ps
module cwr_stage_model (
   input  wire logic       clk_sys_i,  // system clock
   input  wire logic [3:0] fault_i,    // fault command per source
   output logic      [3:0] shdn_n_o    // fault lines, low active
);
   // lines idle high as with a pull-up; a fault takes one edge to show
   initial shdn_n_o = 4'hF;
   always @(posedge clk_sys_i) begin
      shdn_n_o <= ~fault_i;
   end
endmodule // cwr_stage_model
